// ### rtl/strrx_pkg.sv
// constants and types shared by the string receiver files
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package strrx_pkg;
    // register offsets (byte addresses)
    localparam logic [9:0] REG_CTRL    = 10'h000;
    localparam logic [9:0] REG_LEN     = 10'h004;
    localparam logic [9:0] REG_DEST    = 10'h008;
    localparam logic [9:0] REG_ICTO    = 10'h00C;
    localparam logic [9:0] REG_FCTO    = 10'h010;
    localparam logic [9:0] REG_TERM    = 10'h014;
    localparam logic [9:0] REG_STATUS  = 10'h018;
    localparam logic [9:0] REG_INT_ST  = 10'h01C;
    localparam logic [9:0] REG_INT_EN  = 10'h020;
    localparam logic [9:0] REG_INT_CLR = 10'h024;
    localparam logic [9:0] REG_BUF     = 10'h200;  // 128 words of string buffer
    // control fields
    localparam int CTRL_EN     = 0;
    localparam int CTRL_VAR    = 1;
    localparam int CTRL_SWAP   = 2;
    localparam int CTRL_TERM2  = 3;
    localparam int CTRL_PORT_L = 4;  // two-bit port selector at 5:4
    localparam logic [1:0] SECOND_PORT = 2'h2;
    // status / event fields
    localparam int ST_BUSY  = 0;
    localparam int ST_DONE  = 1;
    localparam int ST_ICTO  = 2;
    localparam int ST_FCTO  = 3;
    localparam int ST_OVF   = 4;
    localparam int ST_W     = 5;
    // reset values
    localparam logic [7:0]  LEN_RST  = 8'h01;
    localparam logic [15:0] TERM_RST = 16'h000D;
    // limits and timing
    localparam int MAX_BYTES  = 128;
    localparam int CLK_HZ     = 25_000_000;
    localparam int MS_CYCLES  = CLK_HZ / 1000;
    // states of the receive state machine
    typedef enum {S_IDLE, S_WAIT, S_RECV, S_COPY, S_HOLD} rx_state_t;
endpackage

// ### rtl/strrx_mem_if.sv
// write port between the receiver core and its string memory
`timescale 1ns/1ps
interface strrx_mem_if;
    logic        we;
    logic [6:0]  waddr;
    logic [15:0] wdata;
    modport core (output we, output waddr, output wdata);
    modport mem  (input we, input waddr, input wdata);
endinterface

// ### rtl/strrx_word_mem.sv
// word memory that holds received strings for software to read
`timescale 1ns/1ps
module strrx_word_mem #(
    parameter int DEPTH = 128
) (
    // clock
    input  wire logic               mclk_i,
    // write side
    strrx_mem_if.mem                wr,
    // read side
    input  wire logic [6:0]         raddr_i,
    output      logic [15:0]        rdata_o
);
    logic [15:0] words [DEPTH];

    if (DEPTH < 1 || DEPTH > 128) begin : g_bad_depth
        $error("DEPTH out of range");
    end

    always_ff @(posedge mclk_i) begin
        if (wr.we) begin
            words[wr.waddr] <= wr.wdata;
        end
    end

    always_comb begin
        rdata_o = words[raddr_i];
    end
endmodule // strrx_word_mem

// ### rtl/ascii_string_receiver.sv
// ascii string receiver: serial byte intake, packing, flags and Avalon registers
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ascii_string_receiver
    import strrx_pkg::*;
#(
    parameter int DIV = 217  // cycles per bit at 115200 baud
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // serial input of the second port and its selector strap
    input  wire logic        rxd_i,
    input  wire logic [1:0]  port_sel_i,
    // avalon-mm slave
    input  wire logic [9:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    output      logic [31:0] readdata_o,
    output      logic        waitrequest_o,
    // status
    output      logic        busy_o,
    output      logic        irq_o
);
    if (DIV < 4 || DIV > 65535) begin : g_bad_div
        $error("DIV out of range");
    end

    // -----------------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------------
    logic [5:0]  ctrl_r;
    logic [7:0]  len_r;
    logic [6:0]  dest_r;
    logic [15:0] icto_r;
    logic [15:0] fcto_r;
    logic [15:0] term_r;
    logic [ST_W-1:0] flags_r;
    logic [ST_W-1:0] int_st_r;
    logic [ST_W-1:0] int_en_r;
    logic        rd_pend_r;

    // the strap is a pin, so it passes two flip-flops like the serial line
    logic [1:0]  psel_s1_r;
    logic [1:0]  psel_s2_r;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            psel_s1_r <= 2'h0;
            psel_s2_r <= 2'h0;
        end else begin
            psel_s1_r <= port_sel_i;
            psel_s2_r <= psel_s1_r;
        end
    end

    logic enable;
    logic wr_ok;
    logic [15:0] mem_rdata;
    logic [ST_W-1:0] event_set;

    assign enable = ctrl_r[CTRL_EN] && (ctrl_r[CTRL_PORT_L+1:CTRL_PORT_L] == SECOND_PORT)
                    && (psel_s2_r == SECOND_PORT);
    assign wr_ok  = write_i && !waitrequest_o;
    // reads take one wait cycle so the buffer word is settled
    assign waitrequest_o = read_i && !rd_pend_r;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= 6'h00;
            len_r  <= LEN_RST;
            dest_r <= 7'h00;
            icto_r <= 16'h0000;
            fcto_r <= 16'h0000;
            term_r <= TERM_RST;
        end else if (wr_ok) begin
            unique case (address_i)
                REG_CTRL: ctrl_r <= writedata_i[5:0];
                REG_LEN: begin
                    if (writedata_i[7:0] == 8'h00) len_r <= 8'h01;
                    else if (writedata_i[7:0] > 8'(MAX_BYTES)) len_r <= 8'(MAX_BYTES);
                    else len_r <= writedata_i[7:0];
                end
                REG_DEST: dest_r <= writedata_i[6:0];
                REG_ICTO: icto_r <= writedata_i[15:0];
                REG_FCTO: fcto_r <= writedata_i[15:0];
                REG_TERM: term_r <= writedata_i[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= read_i && !rd_pend_r;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            readdata_o <= 32'h0000_0000;
        end else if (read_i && !rd_pend_r) begin
            if (address_i >= REG_BUF) begin
                readdata_o <= {16'h0000, mem_rdata};
            end else begin
                unique case (address_i)
                    REG_CTRL:   readdata_o <= {26'h0, ctrl_r};
                    REG_LEN:    readdata_o <= {24'h0, len_r};
                    REG_DEST:   readdata_o <= {25'h0, dest_r};
                    REG_ICTO:   readdata_o <= {16'h0, icto_r};
                    REG_FCTO:   readdata_o <= {16'h0, fcto_r};
                    REG_TERM:   readdata_o <= {16'h0, term_r};
                    REG_STATUS: readdata_o <= {27'h0, flags_r};
                    REG_INT_ST: readdata_o <= {27'h0, int_st_r};
                    REG_INT_EN: readdata_o <= {27'h0, int_en_r};
                    default:    readdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------------
    // interrupts
    // -----------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_en_r <= '0;
        end else if (wr_ok && address_i == REG_INT_EN) begin
            int_en_r <= writedata_i[ST_W-1:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_st_r <= '0;
        end else begin
            int_st_r <= (int_st_r & ~((wr_ok && address_i == REG_INT_CLR) ?
                         writedata_i[ST_W-1:0] : '0)) | event_set;
        end
    end

    assign irq_o = |(int_st_r & int_en_r);

    // -----------------------------------------------------------------------
    // serial byte intake
    // -----------------------------------------------------------------------
    logic       rxd_s1_r;
    logic       rxd_s2_r;
    logic [15:0] bcnt_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic       in_byte_r;
    logic       byte_v_r;
    logic [7:0] byte_r;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
        end else begin
            rxd_s1_r <= rxd_i;
            rxd_s2_r <= rxd_s1_r;
        end
    end

    // 8N1 framing, sampled mid-bit
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_byte_r <= 1'b0;
            bcnt_r    <= 16'h0000;
            bit_r     <= 4'h0;
            sh_r      <= 8'h00;
            byte_v_r  <= 1'b0;
            byte_r    <= 8'h00;
        end else begin
            byte_v_r <= 1'b0;
            if (!in_byte_r) begin
                if (!rxd_s2_r) begin
                    in_byte_r <= 1'b1;
                    bcnt_r    <= 16'(DIV / 2);
                    bit_r     <= 4'h0;
                end
            end else if (bcnt_r != 16'h0000) begin
                bcnt_r <= bcnt_r - 16'h0001;
            end else begin
                bcnt_r <= 16'(DIV - 1);
                bit_r  <= bit_r + 4'h1;
                if (bit_r == 4'h0 && rxd_s2_r) begin
                    in_byte_r <= 1'b0;  // false start
                end else if (bit_r >= 4'h1 && bit_r <= 4'h8) begin
                    sh_r <= {rxd_s2_r, sh_r[7:1]};
                end else if (bit_r == 4'h9) begin
                    in_byte_r <= 1'b0;
                    byte_v_r  <= rxd_s2_r;
                    byte_r    <= sh_r;
                end
            end
        end
    end

    // -----------------------------------------------------------------------
    // receive state machine
    // -----------------------------------------------------------------------
    // bytes gather in a staging array so a timed-out string never reaches memory
    logic [7:0]  stage_r [MAX_BYTES];
    rx_state_t   state_r;
    logic [7:0]  cnt_r;
    logic [7:0]  prev_r;
    // 31 bits so the longest timeout of 65535 ms still fits
    logic [30:0] tmr_r;
    logic [6:0]  copy_r;
    logic [6:0]  nwords;
    logic [30:0] ic_lim;
    logic [30:0] fc_lim;
    logic        hit_term;
    strrx_mem_if mbus();

    assign ic_lim = 31'(icto_r * MS_CYCLES);
    assign fc_lim = 31'(fcto_r * MS_CYCLES);
    assign hit_term = ctrl_r[CTRL_TERM2] ? (prev_r == term_r[15:8] && byte_r == term_r[7:0]) && cnt_r != 8'h00
                                         : (byte_r == term_r[7:0]);
    assign nwords = 7'((cnt_r + 8'h01) >> 1);

    // end of string: terminator in variable mode, byte count in fixed mode
    function automatic logic string_ends(input logic var_mode, input logic term_hit,
                                         input logic [7:0] count, input logic [7:0] limit);
        return var_mode ? term_hit : (count == limit);
    endfunction

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= S_IDLE;
            cnt_r   <= 8'h00;
            prev_r  <= 8'h00;
            tmr_r   <= 31'h0;
            copy_r  <= 7'h00;
            flags_r <= '0;
        end else if (!enable) begin
            state_r <= S_IDLE;
            flags_r <= '0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    state_r <= S_WAIT;
                    cnt_r   <= 8'h00;
                    tmr_r   <= 31'h0;
                    flags_r <= '0;
                end
                S_WAIT: begin
                    tmr_r <= tmr_r + 31'h1;
                    if (byte_v_r) begin
                        state_r <= S_RECV;
                        flags_r[ST_BUSY] <= 1'b1;
                        tmr_r   <= 31'h0;
                        stage_r[0] <= byte_r;
                        prev_r  <= byte_r;
                        cnt_r   <= 8'h01;
                        if (string_ends(ctrl_r[CTRL_VAR], hit_term, 8'h01, len_r)) begin
                            state_r <= S_COPY;
                            copy_r  <= 7'h00;
                        end
                    end else if (fcto_r != 16'h0000 && tmr_r >= fc_lim) begin
                        state_r <= S_HOLD;
                        flags_r[ST_FCTO] <= 1'b1;
                    end
                end
                S_RECV: begin
                    tmr_r <= tmr_r + 31'h1;
                    if (byte_v_r) begin
                        tmr_r  <= 31'h0;
                        prev_r <= byte_r;
                        if (ctrl_r[CTRL_VAR] && !hit_term && cnt_r >= len_r) begin
                            state_r <= S_HOLD;
                            flags_r[ST_BUSY] <= 1'b0;
                            flags_r[ST_OVF]  <= 1'b1;
                        end else begin
                            stage_r[cnt_r[6:0]] <= byte_r;
                            cnt_r <= cnt_r + 8'h01;
                            if (string_ends(ctrl_r[CTRL_VAR], hit_term, cnt_r + 8'h01, len_r)) begin
                                state_r <= S_COPY;
                                copy_r  <= 7'h00;
                            end
                        end
                    end else if (icto_r != 16'h0000 && tmr_r >= ic_lim) begin
                        state_r <= S_HOLD;
                        flags_r[ST_BUSY] <= 1'b0;
                        flags_r[ST_ICTO] <= 1'b1;
                    end
                end
                S_COPY: begin
                    copy_r <= copy_r + 7'h01;
                    if (copy_r + 7'h01 >= nwords) begin
                        state_r <= S_HOLD;
                        flags_r[ST_BUSY] <= 1'b0;
                        flags_r[ST_DONE] <= 1'b1;
                    end
                end
                S_HOLD: ;
            endcase
        end
    end

    // each event sets its sticky bit on the rising edge of the status flag
    logic [ST_W-1:0] flags_q_r;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) flags_q_r <= '0;
        else flags_q_r <= flags_r;
    end
    assign event_set = flags_r & ~flags_q_r;
    assign busy_o    = flags_r[ST_BUSY];

    // first byte of a pair is the high byte unless swapped
    logic [7:0] lo_b;
    logic [7:0] hi_b;
    always_comb begin
        hi_b = stage_r[{copy_r[5:0], 1'b0}];
        lo_b = ({1'b0, copy_r, 1'b1} < {1'b0, cnt_r}) ? stage_r[{copy_r[5:0], 1'b1}] : 8'h00;
        mbus.we    = (state_r == S_COPY) && enable;
        mbus.waddr = dest_r + copy_r;
        mbus.wdata = ctrl_r[CTRL_SWAP] ? {lo_b, hi_b} : {hi_b, lo_b};
    end

    strrx_word_mem #(.DEPTH(MAX_BYTES)) u_mem (
        .mclk_i (mclk_i),
        .wr     (mbus.mem),
        .raddr_i(address_i[8:2]),
        .rdata_o(mem_rdata)
    );
endmodule // ascii_string_receiver

// ### bench/strrx_src.sv
// serial ascii source that stands in for the scanner on the second port
`timescale 1ns/1ps
module strrx_src #(
    parameter int DIV = 8
) (
    // clock
    input  wire logic mclk_i,
    // serial line towards the receiver
    output      logic rxd_o
);
    // marking idle level between frames
    initial rxd_o = 1'b1;

    // 8N1 frame, lsb first; gap lets a slow source be modelled
    task automatic send(input logic [7:0] b, input int gap);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= f[i];
            repeat (DIV) @(posedge mclk_i);
        end
        repeat (gap) @(posedge mclk_i);
    endtask
endmodule // strrx_src

// ### bench/strrx_monitor.sv
// port-level assertions for the string receiver
`timescale 1ns/1ps
module strrx_monitor
    import strrx_pkg::*;
#(
    parameter int DIV = 217
) (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        rxd_i,
    input wire logic [1:0]  port_sel_i,
    input wire logic [9:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic        busy_o,
    input wire logic        irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_rd_open;
        $rose(read_i) ##0 waitrequest_o;
    endsequence
    sequence s_rd_done;
        read_i && !waitrequest_o;
    endsequence
    sequence s_disable;
        write_i && address_i == REG_CTRL && !writedata_i[CTRL_EN];
    endsequence

    AST_WR_NOWAIT: assert property (write_i |-> !waitrequest_o)
        else $error("write was stalled");
    AST_RD_FIRST: assert property ($rose(read_i) |-> waitrequest_o)
        else $error("read answered in its first cycle");
    AST_RD_ANSWER: assert property (s_rd_open |=> s_rd_done)
        else $error("read not answered in its second cycle");
    AST_RD_HOLD: assert property (!read_i |=> $stable(readdata_o))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property ((read_i && !waitrequest_o && address_i == 10'h03C) |-> readdata_o == 32'h0)
        else $error("unmapped read gave nonzero data");
    AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(write_i) || $past(write_i, 2))
        else $error("interrupt dropped with no register write");
    AST_BUSY_PORT: assert property ($rose(busy_o) |-> port_sel_i == SECOND_PORT)
        else $error("busy rose on an unselected port");
    AST_BUSY_OFF: assert property (s_disable |=> ##[0:2] !busy_o)
        else $error("busy stayed up after disable");
endmodule // strrx_monitor

bind ascii_string_receiver strrx_monitor #(.DIV(DIV)) u_mon (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .rxd_i(rxd_i), .port_sel_i(port_sel_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .busy_o(busy_o), .irq_o(irq_o));

// ### bench/testbench.sv
// self-checking bench for the ascii string receiver
`timescale 1ns/1ps
`define CMP(nm, s, e) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; $display("mismatch %s exp=%h got=%h", nm, e, s); end end
module testbench
    import strrx_pkg::*;
;
    localparam int DIV   = 8;
    localparam int LIMIT = 95000;
    logic        mclk_i, rst_n_i, rxd_i, read_i, write_i, waitrequest_o, busy_o, irq_o;
    logic [1:0]  port_sel_i;
    logic [9:0]  address_i;
    logic [31:0] writedata_i, readdata_o, rdat, e, m;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0]  b[128];
    logic [7:0]  vs[5] = '{8'h41, 8'h0A, 8'h42, 8'h0D, 8'h0A};
    int          n_mismatch, num_checks, cyc, seed;

    ascii_string_receiver #(.DIV(DIV)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .rxd_i(rxd_i),
        .port_sel_i(port_sel_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .busy_o(busy_o), .irq_o(irq_o));
    strrx_src #(.DIV(DIV)) u_src (.mclk_i(mclk_i), .rxd_o(rxd_i));

    // --------------------------------------------------------------
    // bus master and checking helpers
    // --------------------------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        address_i <= a;
        writedata_i <= d;
        write_i <= 1'b1;
        do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
        write_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // a zero mask marks a poll whose data is not compared
    task automatic rd(input logic [9:0] a, input logic [31:0] x, input logic [31:0] k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        address_i <= a;
        read_i <= 1'b1;
        do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
        rdat = readdata_o;
        read_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic poll(input int n);
        rdat = 32'h0;
        for (int k = 0; k < 2000 && rdat[n] !== 1'b1; k++) begin
            rd(REG_STATUS, 32'h0, 32'h0);
            repeat (20) @(posedge mclk_i);
        end
    endtask

    task automatic lvl(input int w, input logic x);
        @(negedge mclk_i);
        `CMP(w ? "irq_o" : "busy_o", w ? irq_o : busy_o, x)
        @(posedge mclk_i);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // read data is taken at the edge where waitrequest is seen low
    always @(posedge mclk_i) begin
        if (read_i === 1'b1 && waitrequest_o === 1'b0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 32'h0) `CMP("readdata_o", readdata_o & m, e & m)
        end
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        {rst_n_i, read_i, write_i, address_i, writedata_i} = '0;
        port_sel_i = SECOND_PORT;
        seed = 30232;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(REG_LEN, {24'h0, LEN_RST}, 32'hFF);
        rd(REG_TERM, {16'h0, TERM_RST}, 32'hFFFF);
        wr(10'h03C, 32'hFFFF_FFFF);
        rd(10'h03C, 32'h0, 32'hFFFF_FFFF);
        $display("test 1 done");
        // wrong strap, then bytes while disabled, then a real 3-byte string
        port_sel_i <= 2'h0;
        wr(REG_LEN, 32'h3);
        wr(REG_DEST, 32'h5);
        wr(REG_CTRL, 32'h21);
        u_src.send(8'h55, 4);
        rd(REG_STATUS, 32'h0, 32'h1F);
        wr(REG_CTRL, 32'h20);
        port_sel_i <= SECOND_PORT;
        u_src.send(8'h66, 4);
        wr(REG_CTRL, 32'h21);
        for (int i = 0; i < 3; i++) b[i] = 8'($random(seed));
        u_src.send(b[0], 40);
        lvl(0, 1'b1);
        u_src.send(b[1], 40);
        u_src.send(b[2], 0);
        poll(ST_DONE);
        rd(REG_STATUS, 32'h2, 32'h1F);
        rd(10'(REG_BUF + 20), {16'h0, b[0], b[1]}, 32'hFFFF);
        rd(10'(REG_BUF + 24), {16'h0, b[2], 8'h00}, 32'hFFFF);
        wr(REG_CTRL, 32'h20);
        rd(REG_STATUS, 32'h0, 32'h1F);
        $display("test 2 done");
        // full 128-byte string with swap, done interrupt raised, masked, cleared
        wr(REG_INT_CLR, 32'h1F);
        wr(REG_INT_EN, 32'h1 << ST_DONE);
        wr(REG_LEN, 32'h80);
        wr(REG_DEST, 32'h0);
        wr(REG_CTRL, 32'h25);
        for (int i = 0; i < 128; i++) begin
            b[i] = 8'($random(seed));
            u_src.send(b[i], 0);
        end
        poll(ST_DONE);
        lvl(1, 1'b1);
        rd(REG_INT_ST, (32'h1 << ST_DONE) | (32'h1 << ST_BUSY), 32'h1F);
        wr(REG_INT_EN, 32'h0);
        lvl(1, 1'b0);
        wr(REG_INT_CLR, 32'h1 << ST_DONE);
        wr(REG_INT_EN, 32'h1 << ST_DONE);
        lvl(1, 1'b0);
        for (int k = 0; k < 64; k++) rd(10'(REG_BUF + 4 * k), {16'h0, b[2*k+1], b[2*k]}, 32'hFFFF);
        wr(REG_CTRL, 32'h20);
        $display("test 3 done");
        // two-character terminator with a lone second character inside
        wr(REG_LEN, 32'h8);
        wr(REG_DEST, 32'd100);
        wr(REG_TERM, 32'h0D0A);
        wr(REG_CTRL, 32'h2B);
        foreach (vs[i]) u_src.send(vs[i], 10);
        poll(ST_DONE);
        rd(REG_STATUS, 32'h2, 32'h1F);
        rd(10'(REG_BUF + 400), 32'h410A, 32'hFFFF);
        rd(10'(REG_BUF + 404), 32'h420D, 32'hFFFF);
        wr(REG_CTRL, 32'h20);
        // single terminator: overflow past the maximum, then a short string
        wr(REG_LEN, 32'h2);
        wr(REG_TERM, 32'h000D);
        wr(REG_CTRL, 32'h23);
        repeat (3) u_src.send(8'h41, 0);
        poll(ST_OVF);
        rd(REG_STATUS, 32'h1 << ST_OVF, 32'h1E);
        wr(REG_CTRL, 32'h20);
        wr(REG_CTRL, 32'h23);
        u_src.send(8'h31, 0);
        u_src.send(8'h0D, 0);
        poll(ST_DONE);
        rd(10'(REG_BUF + 400), 32'h310D, 32'hFFFF);
        wr(REG_CTRL, 32'h20);
        $display("test 4 done");
        // first-character timeout, held until disable
        wr(REG_LEN, 32'h4);
        wr(REG_DEST, 32'h0);
        wr(REG_FCTO, 32'h1);
        wr(REG_CTRL, 32'h21);
        rd(REG_STATUS, 32'h0, 32'h1F);
        poll(ST_FCTO);
        rd(REG_STATUS, 32'h1 << ST_FCTO, 32'h1F);
        wr(REG_CTRL, 32'h20);
        rd(REG_STATUS, 32'h0, 32'h1F);
        // inter-character timeout leaves the old words untouched
        wr(REG_FCTO, 32'h0);
        wr(REG_ICTO, 32'h1);
        wr(REG_CTRL, 32'h21);
        u_src.send(8'h11, 0);
        u_src.send(8'h22, 0);
        poll(ST_ICTO);
        rd(REG_STATUS, 32'h1 << ST_ICTO, 32'h1E);
        rd(REG_BUF, {16'h0, b[1], b[0]}, 32'hFFFF);
        wr(REG_CTRL, 32'h20);
        rd(REG_STATUS, 32'h0, 32'h1F);
        $display("test 5 done");
        test_done();
    end
endmodule // testbench
